// file: pkg/rf_tx_timing_pkg.sv
// Overview of operation
// R1 - Pulse lasts width value plus one carriers
// R2 - Pulse is cut at end of bit
// R3 - Pulse start follows pulse position type
// R4 - Width applies in Miller mode, incl. symbols
// R5 - Symbol 1 burst length from bits 6:4
// R6 - Symbol 0 burst length from bits 2:0
// R7 - Burst is unmodulated, level from control input
// R8 - Guard wait starts at send or receive end
// R9 - Unit bit 0: 16 carrier cycles
// R10 - Unit bit 1: half bit period
// R11 - Eleven-bit wait: high bits 5:3, low byte
// R12 - Wait is least spacing before next send
// R13 - Type B stop bit and extra guard code
// R14 - Transmit held until guard wait counted down
package rf_tx_timing_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_PULSE_WIDTH  = 8'h2f;
	localparam logic [7:0] ADDR_BURST_LENGTH = 8'h30;
	localparam logic [7:0] ADDR_WAIT_CONTROL = 8'h31;
	localparam logic [7:0] ADDR_WAIT_LOW     = 8'h32;

	// Values after reset
	localparam logic [7:0] RESET_PULSE_WIDTH  = 8'h00;
	localparam logic [7:0] RESET_BURST_LENGTH = 8'h00;
	localparam logic [7:0] RESET_WAIT_CONTROL = 8'hc0;
	localparam logic [7:0] RESET_WAIT_LOW     = 8'h00;

	// Field positions
	localparam int WAIT_ORIGIN_BIT = 7;
	localparam int WAIT_UNIT_BIT   = 6;
	localparam int WAIT_HIGH_MSB   = 5;
	localparam int WAIT_HIGH_LSB   = 3;
	localparam int STOP_CODE_MSB   = 2;
	localparam int SYM1_MSB        = 6;
	localparam int SYM1_LSB        = 4;
	localparam int SYM0_MSB        = 2;

	// Reserved bits of the burst length register read as zero
	localparam logic [7:0] BURST_WRITE_MASK = 8'h77;

	// Cycle counts in carrier ticks
	localparam logic [7:0] CARRIERS_PER_BIT_BASE = 8'h80;
	localparam logic [7:0] GUARD_UNIT_CARRIERS   = 8'h10;

	// Burst length in bits for a 3-bit code
	function automatic logic [8:0] burst_bits(input logic [2:0] code);
		case (code)
			3'h0:    burst_bits = 9'h008;
			3'h1:    burst_bits = 9'h010;
			3'h2:    burst_bits = 9'h020;
			3'h3:    burst_bits = 9'h030;
			3'h4:    burst_bits = 9'h040;
			3'h5:    burst_bits = 9'h060;
			3'h6:    burst_bits = 9'h080;
			default: burst_bits = 9'h100;
		endcase
	endfunction

endpackage

// file: pkg/guard_wait_if.sv
`timescale 1ns/1ps
// Link between the configuration block and its guard wait counter
interface guard_wait_if;
	logic        load;
	logic [10:0] count;
	logic        unitTick;
	logic        busy;
	logic [10:0] remaining;

	modport ctrl  (output load, output count, output unitTick, input busy, input remaining);
	modport timer (input load, input count, input unitTick, output busy, output remaining);
endinterface

// file: rtl/guard_wait_timer.sv
`timescale 1ns/1ps
module guard_wait_timer
	import rf_tx_timing_pkg::*;
(
	input  wire logic   clock,
	input  wire logic   reset_n,
	guard_wait_if.timer gw
);

	logic        busy;
	logic        next_busy;
	logic [10:0] remaining;
	logic [10:0] next_remaining;

	// Load the wait, then count one down per unit tick
	always_comb begin
		next_busy = busy;
		next_remaining = remaining;
		if (gw.load) begin
			next_remaining = gw.count;
			next_busy = (gw.count != 11'h000); // R14
		end else if (busy && gw.unitTick) begin
			next_remaining = remaining - 11'h001;
			next_busy = (remaining != 11'h001); // R14
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy <= 1'b0;
			remaining <= 11'h000;
		end else begin
			busy <= next_busy;
			remaining <= next_remaining;
		end
	end

	assign gw.busy = busy;
	assign gw.remaining = remaining;

endmodule

// file: rtl/rf_tx_timing_modulation_cfg.sv
`timescale 1ns/1ps
module rf_tx_timing_modulation_cfg
	import rf_tx_timing_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [7:0] address,
	input  wire logic [7:0] writeData,
	input  wire logic       writeStrobe,
	input  wire logic       readStrobe,
	output logic      [7:0] readData,
	input  wire logic       carrierTick,
	input  wire logic       txActive,
	input  wire logic       pulseModEnable,
	input  wire logic       millerMode,
	input  wire logic       pulseBit,
	input  wire logic       symbolPulse,
	input  wire logic       pulsePositionType,
	input  wire logic [2:0] bitRateFrequency,
	input  wire logic       burstRequest,
	input  wire logic       burstSymbol,
	input  wire logic       burstLevelControl,
	input  wire logic       typeBFraming,
	input  wire logic       txEnd,
	input  wire logic       rxEnd,
	input  wire logic       txRequest,
	output logic            modOut,
	output logic            bitStart,
	output logic            burstActive,
	output logic            burstLevel,
	output logic            guardWaitBusy,
	output logic            txGrant,
	output logic            stopBit,
	output logic      [2:0] egtCount
);

	guard_wait_if gw ();

	logic [7:0]  pulseWidth;
	logic [7:0]  burstLength;
	logic [7:0]  waitControl;
	logic [7:0]  waitLow;
	logic [7:0]  next_pulseWidth;
	logic [7:0]  next_burstLength;
	logic [7:0]  next_waitControl;
	logic [7:0]  next_waitLow;
	logic [7:0]  next_readData;
	logic [7:0]  carrierInBit;
	logic [7:0]  next_carrierInBit;
	logic [8:0]  pulseLeft;
	logic [8:0]  next_pulseLeft;
	logic        next_modOut;
	logic        next_bitStart;
	logic [8:0]  burstBitsLeft;
	logic [8:0]  next_burstBitsLeft;
	logic        next_burstActive;
	logic        next_burstLevel;
	logic [7:0]  unitCount;
	logic [7:0]  next_unitCount;
	logic        next_txGrant;
	logic        next_stopBit;
	logic [2:0]  next_egtCount;
	logic [7:0]  bitPeriod;
	logic [7:0]  halfBit;
	logic [7:0]  lastIdx;
	logic [7:0]  startPos;
	logic [7:0]  unitTarget;
	logic        bitEdge;
	logic        wantPulse;
	logic        startHit;
	logic        waitStart;
	logic [2:0]  stopCode;

	// Register writes and registered read data
	always_comb begin
		next_pulseWidth = pulseWidth;
		next_burstLength = burstLength;
		next_waitControl = waitControl;
		next_waitLow = waitLow;
		next_readData = 8'h00;
		if (writeStrobe) begin
			case (address)
				ADDR_PULSE_WIDTH:  next_pulseWidth = writeData;
				ADDR_BURST_LENGTH: next_burstLength = writeData & BURST_WRITE_MASK;
				ADDR_WAIT_CONTROL: next_waitControl = writeData;
				ADDR_WAIT_LOW:     next_waitLow = writeData;
				default:           next_waitLow = waitLow;
			endcase
		end
		if (readStrobe) begin
			case (address)
				ADDR_PULSE_WIDTH:  next_readData = pulseWidth;
				ADDR_BURST_LENGTH: next_readData = burstLength;
				ADDR_WAIT_CONTROL: next_readData = waitControl;
				ADDR_WAIT_LOW:     next_readData = waitLow;
				default:           next_readData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pulseWidth <= RESET_PULSE_WIDTH;
			burstLength <= RESET_BURST_LENGTH;
			waitControl <= RESET_WAIT_CONTROL;
			waitLow <= RESET_WAIT_LOW;
			readData <= 8'h00;
		end else begin
			pulseWidth <= next_pulseWidth;
			burstLength <= next_burstLength;
			waitControl <= next_waitControl;
			waitLow <= next_waitLow;
			readData <= next_readData;
		end
	end

	// Bit grid in carrier ticks, derived from the bit rate setting
	always_comb begin
		bitPeriod = CARRIERS_PER_BIT_BASE >> bitRateFrequency;
		halfBit = (bitPeriod == 8'h01) ? 8'h01 : (bitPeriod >> 1);
		lastIdx = bitPeriod - 8'h01;
		startPos = pulsePositionType ? halfBit : 8'h00; // R3
		bitEdge = carrierTick && txActive && (carrierInBit == lastIdx);
		wantPulse = millerMode && ((pulseModEnable && pulseBit) || symbolPulse); // R4
		startHit = carrierTick && txActive && wantPulse && (carrierInBit == startPos); // R3
	end

	// Pulse counter: width plus one carriers, cut at the bit boundary
	always_comb begin
		next_carrierInBit = carrierInBit;
		next_pulseLeft = pulseLeft;
		if (!txActive) begin
			next_carrierInBit = 8'h00;
			next_pulseLeft = 9'h000;
		end else if (carrierTick) begin
			next_carrierInBit = bitEdge ? 8'h00 : carrierInBit + 8'h01;
			if (startHit) begin
				next_pulseLeft = {1'b0, pulseWidth} + 9'h001; // R1
			end else if (bitEdge) begin
				next_pulseLeft = 9'h000; // R2
			end else if (pulseLeft != 9'h000) begin
				next_pulseLeft = pulseLeft - 9'h001; // R1
			end
		end
		next_modOut = (next_pulseLeft != 9'h000);
		next_bitStart = bitEdge;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			carrierInBit <= 8'h00;
			pulseLeft <= 9'h000;
			modOut <= 1'b0;
			bitStart <= 1'b0;
		end else begin
			carrierInBit <= next_carrierInBit;
			pulseLeft <= next_pulseLeft;
			modOut <= next_modOut;
			bitStart <= next_bitStart;
		end
	end

	// Burst of unmodulated subcarrier, counted in bits
	always_comb begin
		next_burstBitsLeft = burstBitsLeft;
		if (burstRequest) begin
			if (burstSymbol) begin
				next_burstBitsLeft = burst_bits(burstLength[SYM1_MSB:SYM1_LSB]); // R5
			end else begin
				next_burstBitsLeft = burst_bits(burstLength[SYM0_MSB:0]); // R6
			end
		end else if (bitEdge && (burstBitsLeft != 9'h000)) begin
			next_burstBitsLeft = burstBitsLeft - 9'h001;
		end
		next_burstActive = (next_burstBitsLeft != 9'h000);
		next_burstLevel = burstLevelControl; // R7
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			burstBitsLeft <= 9'h000;
			burstActive <= 1'b0;
			burstLevel <= 1'b0;
		end else begin
			burstBitsLeft <= next_burstBitsLeft;
			burstActive <= next_burstActive;
			burstLevel <= next_burstLevel;
		end
	end

	// Guard wait start, time unit and transmit gate
	always_comb begin
		waitStart = waitControl[WAIT_ORIGIN_BIT] ? rxEnd : txEnd; // R8
		unitTarget = waitControl[WAIT_UNIT_BIT] ? halfBit : GUARD_UNIT_CARRIERS; // R9 R10
		gw.load = waitStart;
		gw.count = {waitControl[WAIT_HIGH_MSB:WAIT_HIGH_LSB], waitLow}; // R11
		gw.unitTick = carrierTick && (unitCount == unitTarget - 8'h01);
		next_unitCount = unitCount;
		if (waitStart || gw.unitTick) begin
			next_unitCount = 8'h00;
		end else if (carrierTick) begin
			next_unitCount = unitCount + 8'h01;
		end
		next_txGrant = txRequest && !gw.busy && !waitStart; // R12 R14
		stopCode = waitControl[STOP_CODE_MSB:0];
		next_stopBit = typeBFraming && (stopCode != 3'h0); // R13
		next_egtCount = (typeBFraming && (stopCode > 3'h1)) ? stopCode - 3'h1 : 3'h0; // R13
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			unitCount <= 8'h00;
			txGrant <= 1'b0;
			stopBit <= 1'b0;
			egtCount <= 3'h0;
		end else begin
			unitCount <= next_unitCount;
			txGrant <= next_txGrant;
			stopBit <= next_stopBit;
			egtCount <= next_egtCount;
		end
	end

	guard_wait_timer u_timer (
		.clock   (clock),
		.reset_n (reset_n),
		.gw      (gw.timer)
	);

	assign guardWaitBusy = gw.busy;

	// Checks on the block's own behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_pulse_width;
		startHit |=> pulseLeft == {1'b0, $past(pulseWidth)} + 9'h001;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse length wrong"); // R1

	property p_pulse_cut;
		bitEdge && !startHit |=> !modOut;
	endproperty
	a_pulse_cut: assert property (p_pulse_cut) else $error("pulse crossed bit end"); // R2

	property p_pulse_pos;
		$rose(modOut) |-> $past(carrierInBit) == $past(startPos);
	endproperty
	a_pulse_pos: assert property (p_pulse_pos) else $error("pulse start misplaced"); // R3

	property p_pulse_miller;
		$rose(modOut) |-> $past(millerMode);
	endproperty
	a_pulse_miller: assert property (p_pulse_miller) else $error("pulse outside Miller"); // R4

	property p_burst_one;
		burstRequest && burstSymbol |=> burstBitsLeft == burst_bits($past(burstLength[6:4]));
	endproperty
	a_burst_one: assert property (p_burst_one) else $error("symbol 1 burst length"); // R5

	property p_burst_zero;
		burstRequest && !burstSymbol |=>
			burstActive && burstBitsLeft == burst_bits($past(burstLength[2:0]));
	endproperty
	a_burst_zero: assert property (p_burst_zero) else $error("symbol 0 burst length"); // R6

	property p_burst_level;
		burstActive |-> burstLevel == $past(burstLevelControl);
	endproperty
	a_burst_level: assert property (p_burst_level) else $error("burst level wrong"); // R7

	sequence s_wait_event;
		(waitControl[7] ? rxEnd : txEnd) && gw.count != 11'h000;
	endsequence
	property p_wait_origin;
		s_wait_event |=> guardWaitBusy ##0 gw.remaining == $past(gw.count);
	endproperty
	a_wait_origin: assert property (p_wait_origin) else $error("guard wait not started"); // R8 R11

	property p_unit_sixteen;
		gw.unitTick && !waitControl[6] |-> unitCount == 8'h0f;
	endproperty
	a_unit_sixteen: assert property (p_unit_sixteen) else $error("unit not 16 carriers"); // R9

	property p_unit_half;
		gw.unitTick && waitControl[6] |-> unitCount == halfBit - 8'h01;
	endproperty
	a_unit_half: assert property (p_unit_half) else $error("unit not half bit"); // R10

	property p_hold_tx;
		guardWaitBusy |=> !txGrant;
	endproperty
	a_hold_tx: assert property (p_hold_tx) else $error("transmit during guard wait"); // R12 R14

	property p_egt;
		typeBFraming && waitControl[2:0] > 3'h1 ##1 $stable(waitControl) |->
			egtCount == waitControl[2:0] - 3'h1 && stopBit;
	endproperty
	a_egt: assert property (p_egt) else $error("extra guard count wrong"); // R13

	// Running pulse ends once its last carrier tick is counted
	property p_pulse_end;
		carrierTick && txActive && !startHit && !bitEdge && pulseLeft == 9'h001 |=> !modOut;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse too long"); // R1

	// Burst loses one bit at each bit boundary
	property p_burst_step;
		bitEdge && !burstRequest && burstBitsLeft != 9'h000 |=>
			burstBitsLeft == $past(burstBitsLeft) - 9'h001;
	endproperty
	a_burst_step: assert property (p_burst_step) else $error("burst count step"); // R5 R6

	// Guard wait ends after its last unit
	property p_wait_end;
		guardWaitBusy && gw.unitTick && gw.remaining == 11'h001 && !gw.load |=> !guardWaitBusy;
	endproperty
	a_wait_end: assert property (p_wait_end) else $error("guard wait overran"); // R12

	// A free transmitter is granted in the next cycle
	sequence s_tx_free;
		txRequest && !guardWaitBusy && !waitStart;
	endsequence
	property p_grant_free;
		s_tx_free |=> txGrant;
	endproperty
	a_grant_free: assert property (p_grant_free) else $error("grant withheld"); // R14

endmodule

// file: dv/rf_field_partner.sv
`timescale 1ns/1ps
module rf_field_partner (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic answerDone,
	output logic      carrierTick,
	output logic      rxEnd
);
	logic [1:0] phase;

	// Carrier divider: one tick every third clock, near the field rate
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			phase <= 2'h0;
			rxEnd <= 1'b0;
		end else begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			rxEnd <= answerDone; // End of the card answer, one cycle long
		end
	end

	assign carrierTick = reset_n && (phase == 2'h2);
endmodule

// file: dv/rf_tx_timing_modulation_cfg_bench.sv
`timescale 1ns/1ps
module rf_tx_timing_modulation_cfg_bench import rf_tx_timing_pkg::*;;
	logic       clock = 0, reset_n = 0, writeStrobe = 0, readStrobe = 0;
	logic [7:0] address = 8'h00, writeData = 8'h00, readData;
	logic       txActive = 0, millerMode = 0, pulseBit = 0, pulsePositionType = 0;
	logic       pulseModEnable = 1, symbolPulse = 0;
	logic       burstRequest = 0, burstSymbol = 0, burstLevelControl = 0;
	logic       typeBFraming = 0, txEnd = 0, txRequest = 0, answerDone = 0;
	logic [2:0] bitRateFrequency = 3'h0, egtCount;
	logic       carrierTick, rxEnd, modOut, bitStart, burstActive, burstLevel;
	logic       guardWaitBusy, txGrant, stopBit, grantSeen;
	logic [7:0] gctl [3] = '{8'h00, 8'h80, 8'h60};
	logic [7:0] glow [3] = '{8'h03, 8'h03, 8'h02};
	int         gexp [3] = '{48, 48, 4104};
	int         blen [8] = '{8, 16, 32, 48, 64, 96, 128, 256};
	int         mismatches = 0, checksDone = 0;

	// Clock at 40 MHz
	initial begin
		forever #12.5 clock = ~clock;
	end

	rf_tx_timing_modulation_cfg DUT (.clock(clock), .reset_n(reset_n), .address(address),
		.writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
		.readData(readData), .carrierTick(carrierTick), .txActive(txActive),
		.pulseModEnable(pulseModEnable), .millerMode(millerMode), .pulseBit(pulseBit),
		.symbolPulse(symbolPulse), .pulsePositionType(pulsePositionType),
		.bitRateFrequency(bitRateFrequency), .burstRequest(burstRequest),
		.burstSymbol(burstSymbol), .burstLevelControl(burstLevelControl),
		.typeBFraming(typeBFraming), .txEnd(txEnd), .rxEnd(rxEnd), .txRequest(txRequest),
		.modOut(modOut), .bitStart(bitStart), .burstActive(burstActive),
		.burstLevel(burstLevel), .guardWaitBusy(guardWaitBusy), .txGrant(txGrant),
		.stopBit(stopBit), .egtCount(egtCount));

	rf_field_partner card (.clock(clock), .reset_n(reset_n), .answerDone(answerDone),
		.carrierTick(carrierTick), .rxEnd(rxEnd));

	// Mismatch report and counted compares
	task automatic fail(input string msg);
		mismatches++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checksDone++;
		if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
	endtask
	task automatic near(input int got, input int exp, input string msg);
		checksDone++;
		if (got < exp - 1 || got > exp + 1) fail($sformatf("%s got %0d want %0d", msg, got, exp));
	endtask

	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
		@(posedge clock);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 chk(readData, exp, msg);
	endtask

	// One-cycle event: 0 send end, 1 card answer end, else burst request
	task automatic strobe(input int which);
		@(posedge clock);
		case (which)
			0: txEnd <= 1'b1;
			1: answerDone <= 1'b1;
			default: burstRequest <= 1'b1;
		endcase
		@(posedge clock);
		txEnd <= 1'b0;
		answerDone <= 1'b0;
		burstRequest <= 1'b0;
	endtask

	// Carrier ticks while modOut, burstActive or guardWaitBusy is high, bounded
	task automatic measure(input int sel, output int ticks);
		int   n;
		logic seen;
		logic s;
		ticks = 0;
		seen = 1'b0;
		grantSeen = 1'b0;
		for (n = 0; n < 20000; n++) begin
			@(posedge clock);
			s = (sel == 0) ? modOut : (sel == 1) ? burstActive : guardWaitBusy;
			if (s === 1'b1) begin
				seen = 1'b1;
				grantSeen = grantSeen | (txGrant === 1'b1);
				if (carrierTick === 1'b1) ticks++;
			end else if (seen) begin
				break;
			end
		end
		if (n == 20000) begin
			fail("wait bound used up");
			give_verdict();
		end
	endtask

	// Counts and verdict
	task automatic give_verdict();
		$display("mismatches %0d, compares %0d", mismatches, checksDone);
		if (mismatches == 0 && checksDone > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		int c;
		int t;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		rd(ADDR_WAIT_CONTROL, 8'hc0, "control reset");
		rd(ADDR_WAIT_LOW, RESET_WAIT_LOW, "low reset");
		rd(8'h33, 8'h00, "unmapped read");
		wr(ADDR_BURST_LENGTH, 8'hff);
		rd(ADDR_BURST_LENGTH, 8'h77, "burst reserved bits");
		wr(8'h33, 8'h5a);
		wr(ADDR_PULSE_WIDTH, 8'ha5);
		rd(ADDR_PULSE_WIDTH, 8'ha5, "width readback");
		@(posedge clock);
		typeBFraming <= 1'b1;
		for (c = 0; c < 8; c++) begin
			wr(ADDR_WAIT_CONTROL, 8'(c));
			rd(ADDR_WAIT_CONTROL, 8'(c), "control readback");
			chk({7'h00, stopBit}, {7'h00, c != 0}, "stop bit");
			chk({5'h00, egtCount}, (c >= 2) ? 8'(c - 1) : 8'h00, "extra guard");
		end
		@(posedge clock);
		typeBFraming <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk({4'h0, stopBit, egtCount}, 8'h00, "stop outside Type B");
		// Pulses in Miller mode at the slowest bit rate
		@(posedge clock);
		txActive <= 1'b1;
		millerMode <= 1'b1;
		wr(ADDR_PULSE_WIDTH, 8'h04);
		pulseBit <= 1'b1;
		measure(0, t);
		near(t, 5, "pulse width");
		pulseBit <= 1'b0;
		// Start and stop symbols pulse with the same width
		pulseModEnable <= 1'b0;
		symbolPulse <= 1'b1;
		measure(0, t);
		near(t, 5, "symbol pulse width");
		symbolPulse <= 1'b0;
		pulseModEnable <= 1'b1;
		pulsePositionType <= 1'b1;
		wr(ADDR_PULSE_WIDTH, 8'hff);
		pulseBit <= 1'b1;
		measure(0, t);
		near(t, 64, "pulse cut at bit end");
		pulseBit <= 1'b0;
		millerMode <= 1'b0;
		wr(ADDR_PULSE_WIDTH, 8'h04);
		pulseBit <= 1'b1;
		t = 0;
		repeat (450) @(posedge clock) if (modOut === 1'b1) t++;
		chk(8'(t), 8'h00, "pulse without Miller");
		pulseBit <= 1'b0;
		// Bit grid: carrier ticks from one bit start pulse to the next
		t = 0;
		c = 0;
		for (int n = 0; n < 1000 && c < 2; n++) begin
			@(posedge clock);
			if (c == 1 && carrierTick === 1'b1) t++;
			if (bitStart === 1'b1) c++;
		end
		if (c < 2) begin
			fail("bit grid bound used up");
			give_verdict();
		end
		near(t, 128, "bit period");
		// Bursts, one bit per carrier tick
		bitRateFrequency <= 3'h7;
		for (c = 0; c < 8; c++) begin
			wr(ADDR_BURST_LENGTH, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
			burstSymbol <= 1'b1;
			burstLevelControl <= c[0];
			strobe(2);
			measure(1, t);
			near(t, blen[c], "symbol 1 burst");
			chk({7'h00, burstLevel}, {7'h00, c[0]}, "burst level");
			burstSymbol <= 1'b0;
			strobe(2);
			measure(1, t);
			near(t, blen[7 - c], "symbol 0 burst");
		end
		// Guard wait from send end, answer end, and in half-bit units
		txRequest <= 1'b1;
		bitRateFrequency <= 3'h4;
		for (c = 0; c < 3; c++) begin
			wr(ADDR_WAIT_CONTROL, gctl[c]);
			wr(ADDR_WAIT_LOW, glow[c]);
			strobe(c == 1);
			measure(2, t);
			near(t, gexp[c], "guard wait length");
			chk({7'h00, grantSeen}, 8'h00, "grant during wait");
			repeat (2) @(posedge clock);
			#1 chk({7'h00, txGrant}, 8'h01, "grant after wait");
		end
		wr(ADDR_WAIT_CONTROL, 8'h80);
		strobe(0);
		repeat (3) @(posedge clock);
		#1 chk({7'h00, guardWaitBusy}, 8'h00, "send end ignored");
		give_verdict();
	end
endmodule
